// ### logic/cbrm_pkg.sv
package cbrm_pkg;

  localparam int ADDR_W      = 9;
  localparam int DATA_W      = 8;
  localparam int NUM_RW      = 19;
  localparam int NUM_LAT     = 11;
  localparam int LIMIT_DEPTH = 32;
  localparam int LIMIT_AW    = 5;
  localparam int SYNC_W      = 19;

  typedef logic [ADDR_W-1:0] cbrm_addr_t;
  typedef logic [DATA_W-1:0] cbrm_byte_t;

  typedef enum logic [1:0] {
    CBRM_IDLE = 2'h0,
    CBRM_ACK  = 2'h1
  } cbrm_bus_t;

  // synchronised bus vector layout
  localparam int SYNC_CS_N = 18;
  localparam int SYNC_RD   = 17;
  localparam int SYNC_A_HI = 16;
  localparam int SYNC_A_LO = 8;
  localparam logic [SYNC_W-1:0] SYNC_RST = 19'h40000;

  localparam cbrm_byte_t ZERO_BYTE = 8'h00;
  // arbitrary identification values
  localparam cbrm_byte_t MAC_REVISION   = 8'h5A;
  localparam cbrm_byte_t SYSIF_REVISION = 8'hA5;

  // plain read/write registers, all clear to zero
  localparam cbrm_addr_t RW_OFS [NUM_RW] = '{
    9'h000, 9'h001, 9'h002, 9'h005, 9'h008, 9'h011, 9'h013, 9'h015, 9'h019, 9'h01D,
    9'h02D, 9'h02F, 9'h100, 9'h101, 9'h105, 9'h107, 9'h109, 9'h10B, 9'h10F};
  localparam int IX_MAC_MODE_0     = 0;
  localparam int IX_MAC_COMPARE    = 4;
  localparam int IX_RING_MASK_0    = 5;
  localparam int IX_RING_MASK_1    = 6;
  localparam int IX_TOKEN_MASK     = 7;
  localparam int IX_CNT_INC_MASK   = 8;
  localparam int IX_CNT_OVF_MASK   = 9;
  localparam int IX_EXC_MASK       = 10;
  localparam int IX_INT_MASK       = 11;
  localparam int IX_SYSIF_MODE_0   = 12;
  localparam int IX_SYSIF_MODE_1   = 13;
  localparam int IX_MASTER_NOTIFY  = 14;
  localparam int IX_STATE_NOTIFY   = 15;
  localparam int IX_SERVICE_NOTIFY = 16;
  localparam int IX_NOSPACE_NOTIFY = 17;
  localparam int IX_REQUEST_NOTIFY = 18;

  // event latches and attention registers, conditional write
  localparam cbrm_addr_t LAT_OFS [NUM_LAT] = '{
    9'h010, 9'h012, 9'h014, 9'h018, 9'h01C, 9'h028, 9'h02C, 9'h106, 9'h108, 9'h10A, 9'h10E};
  localparam cbrm_byte_t LAT_RST [NUM_LAT] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h0F, 8'hFF, 8'h00};
  localparam int L_RING_0  = 0;
  localparam int L_RING_1  = 1;
  localparam int L_TOKEN   = 2;
  localparam int L_CNT_INC = 3;
  localparam int L_CNT_OVF = 4;
  localparam int L_INTERN  = 5;
  localparam int L_EXC     = 6;
  localparam int L_STATE   = 7;
  localparam int L_SERVICE = 8;
  localparam int L_NOSPACE = 9;
  localparam int L_REQUEST = 10;

  localparam cbrm_addr_t OFS_MAC_REV     = 9'h007;
  localparam cbrm_addr_t OFS_RX_STATUS   = 9'h00C;
  localparam cbrm_addr_t OFS_TX_STATUS   = 9'h00E;
  localparam cbrm_addr_t OFS_INT_COND    = 9'h02E;
  localparam cbrm_addr_t OFS_PTR_RAM     = 9'h102;
  localparam cbrm_addr_t OFS_MAILBOX     = 9'h103;
  localparam cbrm_addr_t OFS_MASTER_ATTN = 9'h104;
  localparam cbrm_addr_t OFS_LIMIT_ADDR  = 9'h10C;
  localparam cbrm_addr_t OFS_LIMIT_DATA  = 9'h10D;
  localparam cbrm_addr_t OFS_SYSIF_CMP   = 9'h11F;

endpackage

// ### logic/cbrm_regbank.sv
// Summary of operation
// - address bit 8 selects MAC or system group
// - controller reads and writes registers over bus
// - mac mode 0 always read/write, resets 00
// - both system mode registers read/write, reset zero
// - receiver status read-only, writes dropped, resets 00
// - transmitter status read-only, writes ignored, resets zero
// - interrupt condition read-only; its mask writable
// - ring latch 0 conditional write; mask always
// - token/timer latch conditional; mask always; reset zero
// - counter increment latch conditional; mask always writable
// - counter overflow latch conditional; mask always writable
// - internal event latch readable, conditional write, zero
// - exception status conditional; exception mask always writable
// - master attention read-only, resets 00
// - state attention conditional write, resets 07
// - service attention conditional write, resets 0F
// - no-space attention conditional write, resets FF
// - limit RAM reached only through address/data
// - byte bit 7 is most significant
// - system compare read/write, kept across reset
`timescale 1ns/100ps
module cbrm_regbank
  import cbrm_pkg::*;
(
  input  wire logic              REF_CLK,
  input  wire logic              RST_N,
  input  wire logic              CB_CS_N,
  input  wire logic              CB_READ,
  input  wire logic [ADDR_W-1:0] CB_ADDR,
  input  wire logic [DATA_W-1:0] CB_DIN,
  output logic      [DATA_W-1:0] CB_DOUT,
  output logic                   CB_DOE,
  output logic                   CB_ACK_N,
  input  wire logic [DATA_W-1:0] RX_STATUS,
  input  wire logic [DATA_W-1:0] TX_STATUS,
  input  wire logic [DATA_W-1:0] EV_RING_0,
  input  wire logic [DATA_W-1:0] EV_RING_1,
  input  wire logic [DATA_W-1:0] EV_TOKEN_TIMER,
  input  wire logic [DATA_W-1:0] EV_CNT_INC,
  input  wire logic [DATA_W-1:0] EV_CNT_OVF,
  input  wire logic [DATA_W-1:0] EV_INTERNAL,
  input  wire logic [DATA_W-1:0] EV_EXCEPTION,
  input  wire logic [DATA_W-1:0] EV_STATE,
  input  wire logic [DATA_W-1:0] EV_SERVICE,
  input  wire logic [DATA_W-1:0] EV_NO_SPACE,
  input  wire logic [DATA_W-1:0] EV_REQUEST,
  output logic      [DATA_W-1:0] MAC_MODE_0,
  output logic      [DATA_W-1:0] SYSIF_MODE_0,
  output logic      [DATA_W-1:0] SYSIF_MODE_1,
  output logic      [DATA_W-1:0] INT_CONDITION,
  output logic      [DATA_W-1:0] MASTER_ATTN
);

  logic [SYNC_W-1:0] bus_sync1_ff;
  logic [SYNC_W-1:0] bus_sync2_ff;
  cbrm_bus_t         bus_state_ff;
  cbrm_bus_t         nxt_bus_state;
  logic              sel;
  logic              start;
  logic              acc_wr;
  logic              acc_rd;
  cbrm_addr_t        acc_addr;
  cbrm_byte_t        acc_data;
  cbrm_byte_t        rd_data;
  cbrm_byte_t        dout_ff;
  logic              doe_ff;
  logic              ack_n_ff;
  cbrm_byte_t        rw_ff      [NUM_RW];
  cbrm_byte_t        lat_ff     [NUM_LAT];
  cbrm_byte_t        nxt_lat    [NUM_LAT];
  cbrm_byte_t        ev         [NUM_LAT];
  cbrm_byte_t        rx_status_ff;
  cbrm_byte_t        tx_status_ff;
  cbrm_byte_t        int_cond_ff;
  cbrm_byte_t        nxt_int_cond;
  cbrm_byte_t        master_attn_ff;
  cbrm_byte_t        nxt_master_attn;
  cbrm_byte_t        ptr_ram_ff;
  cbrm_byte_t        mailbox_ff;
  cbrm_byte_t        sysif_cmp_ff;
  cbrm_byte_t        limit_addr_ff;
  cbrm_byte_t        limit_ram  [LIMIT_DEPTH];

  // write strobe for one offset
  function automatic logic wr_hit(input logic wr, input cbrm_addr_t a, input cbrm_addr_t ofs);
    wr_hit = wr && (a == ofs);
  endfunction

  // masked any-bit-set
  function automatic logic any_masked(input cbrm_byte_t v, input cbrm_byte_t m);
    any_masked = |(v & m);
  endfunction

  assign ev[L_RING_0]  = EV_RING_0;
  assign ev[L_RING_1]  = EV_RING_1;
  assign ev[L_TOKEN]   = EV_TOKEN_TIMER;
  assign ev[L_CNT_INC] = EV_CNT_INC;
  assign ev[L_CNT_OVF] = EV_CNT_OVF;
  assign ev[L_INTERN]  = EV_INTERNAL;
  assign ev[L_EXC]     = EV_EXCEPTION;
  assign ev[L_STATE]   = EV_STATE;
  assign ev[L_SERVICE] = EV_SERVICE;
  assign ev[L_NOSPACE] = EV_NO_SPACE;
  assign ev[L_REQUEST] = EV_REQUEST;

  // pin synchroniser, two stages
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      bus_sync1_ff <= SYNC_RST;
      bus_sync2_ff <= SYNC_RST;
    end else begin
      bus_sync1_ff <= {CB_CS_N, CB_READ, CB_ADDR, CB_DIN};
      bus_sync2_ff <= bus_sync1_ff;
    end
  end

  assign sel      = !bus_sync2_ff[SYNC_CS_N];
  assign start    = sel && (bus_state_ff == CBRM_IDLE);
  assign acc_rd   = start && bus_sync2_ff[SYNC_RD];
  assign acc_wr   = start && !bus_sync2_ff[SYNC_RD];
  assign acc_addr = bus_sync2_ff[SYNC_A_HI:SYNC_A_LO];
  assign acc_data = bus_sync2_ff[DATA_W-1:0];  // bit 7 is the msb

  // one access per select assertion
  always_comb begin
    nxt_bus_state = bus_state_ff;
    case (bus_state_ff)
      CBRM_IDLE: begin
        if (sel) begin
          nxt_bus_state = CBRM_ACK;
        end
      end
      CBRM_ACK: begin
        if (!sel) begin
          nxt_bus_state = CBRM_IDLE;
        end
      end
      default: begin
        nxt_bus_state = CBRM_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      bus_state_ff <= CBRM_IDLE;
    end else begin
      bus_state_ff <= nxt_bus_state;
    end
  end

  // read mux; group split by address bit 8
  always_comb begin
    rd_data = ZERO_BYTE;  // reserved reads as zero
    case (acc_addr)
      OFS_MAC_REV:     rd_data = MAC_REVISION;
      OFS_RX_STATUS:   rd_data = rx_status_ff;
      OFS_TX_STATUS:   rd_data = tx_status_ff;
      OFS_INT_COND:    rd_data = int_cond_ff;
      OFS_PTR_RAM:     rd_data = ptr_ram_ff;
      OFS_MAILBOX:     rd_data = mailbox_ff;
      OFS_MASTER_ATTN: rd_data = master_attn_ff;
      OFS_LIMIT_ADDR:  rd_data = limit_addr_ff;
      OFS_LIMIT_DATA:  rd_data = limit_ram[limit_addr_ff[LIMIT_AW-1:0]];
      OFS_SYSIF_CMP:   rd_data = sysif_cmp_ff;
      default: begin
        for (int i = 0; i < NUM_RW; i++) begin
          if (acc_addr == RW_OFS[i]) begin
            rd_data = rw_ff[i];
          end
        end
        for (int i = 0; i < NUM_LAT; i++) begin
          if (acc_addr == LAT_OFS[i]) begin
            rd_data = lat_ff[i];
          end
        end
      end
    endcase
  end

  // bus answer
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      dout_ff  <= ZERO_BYTE;
      doe_ff   <= 1'b0;
      ack_n_ff <= 1'b1;
    end else if (start) begin
      dout_ff  <= acc_rd ? rd_data : ZERO_BYTE;
      doe_ff   <= acc_rd;
      ack_n_ff <= 1'b0;
    end else if (!sel) begin
      doe_ff   <= 1'b0;
      ack_n_ff <= 1'b1;
    end
  end

  // plain read/write registers
  always_ff @(posedge REF_CLK) begin
    for (int i = 0; i < NUM_RW; i++) begin
      if (!RST_N) begin
        rw_ff[i] <= ZERO_BYTE;
      end else if (wr_hit(acc_wr, acc_addr, RW_OFS[i])) begin
        rw_ff[i] <= acc_data;
      end
    end
  end

  // conditional write against group compare; events win
  always_comb begin
    for (int i = 0; i < NUM_LAT; i++) begin
      nxt_lat[i] = lat_ff[i];
      if (wr_hit(acc_wr, acc_addr, LAT_OFS[i]) &&
          (lat_ff[i] == (LAT_OFS[i][ADDR_W-1] ? sysif_cmp_ff : rw_ff[IX_MAC_COMPARE]))) begin
        nxt_lat[i] = acc_data;
      end
      nxt_lat[i] = nxt_lat[i] | ev[i];
    end
  end

  always_ff @(posedge REF_CLK) begin
    for (int i = 0; i < NUM_LAT; i++) begin
      if (!RST_N) begin
        lat_ff[i] <= LAT_RST[i];
      end else begin
        lat_ff[i] <= nxt_lat[i];
      end
    end
  end

  // status snapshots; bus writes never reach them
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      rx_status_ff <= ZERO_BYTE;
      tx_status_ff <= ZERO_BYTE;
    end else begin
      rx_status_ff <= RX_STATUS;
      tx_status_ff <= TX_STATUS;
    end
  end

  // interrupt condition from latches and masks
  always_comb begin
    nxt_int_cond    = ZERO_BYTE;
    nxt_int_cond[0] = any_masked(lat_ff[L_RING_0], rw_ff[IX_RING_MASK_0]);
    nxt_int_cond[1] = any_masked(lat_ff[L_RING_1], rw_ff[IX_RING_MASK_1]);
    nxt_int_cond[2] = any_masked(lat_ff[L_TOKEN], rw_ff[IX_TOKEN_MASK]);
    nxt_int_cond[3] = any_masked(lat_ff[L_CNT_INC], rw_ff[IX_CNT_INC_MASK]);
    nxt_int_cond[4] = any_masked(lat_ff[L_CNT_OVF], rw_ff[IX_CNT_OVF_MASK]);
    nxt_int_cond[5] = any_masked(lat_ff[L_EXC], rw_ff[IX_EXC_MASK]);
    nxt_int_cond[6] = |lat_ff[L_INTERN];
    nxt_int_cond[7] = any_masked(master_attn_ff, rw_ff[IX_MASTER_NOTIFY]);
  end

  // master attention from attention and notify pairs
  always_comb begin
    nxt_master_attn    = ZERO_BYTE;
    nxt_master_attn[0] = any_masked(lat_ff[L_STATE], rw_ff[IX_STATE_NOTIFY]);
    nxt_master_attn[1] = any_masked(lat_ff[L_SERVICE], rw_ff[IX_SERVICE_NOTIFY]);
    nxt_master_attn[2] = any_masked(lat_ff[L_NOSPACE], rw_ff[IX_NOSPACE_NOTIFY]);
    nxt_master_attn[3] = any_masked(lat_ff[L_REQUEST], rw_ff[IX_REQUEST_NOTIFY]);
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      int_cond_ff    <= ZERO_BYTE;
      master_attn_ff <= ZERO_BYTE;
    end else begin
      int_cond_ff    <= nxt_int_cond;
      master_attn_ff <= nxt_master_attn;
    end
  end

  // mailbox holds revision code until overwritten
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      mailbox_ff <= SYSIF_REVISION;
    end else if (wr_hit(acc_wr, acc_addr, OFS_MAILBOX)) begin
      mailbox_ff <= acc_data;
    end
  end

  // registers untouched by reset
  always_ff @(posedge REF_CLK) begin
    if (wr_hit(acc_wr, acc_addr, OFS_PTR_RAM)) begin
      ptr_ram_ff <= acc_data;
    end
    if (wr_hit(acc_wr, acc_addr, OFS_SYSIF_CMP)) begin
      sysif_cmp_ff <= acc_data;
    end
    if (wr_hit(acc_wr, acc_addr, OFS_LIMIT_ADDR)) begin
      limit_addr_ff <= acc_data;
    end
  end

  // limit RAM, indirect only
  always_ff @(posedge REF_CLK) begin
    if (wr_hit(acc_wr, acc_addr, OFS_LIMIT_DATA)) begin
      limit_ram[limit_addr_ff[LIMIT_AW-1:0]] <= acc_data;
    end
  end

  assign CB_DOUT       = dout_ff;
  assign CB_DOE        = doe_ff;
  assign CB_ACK_N      = ack_n_ff;
  assign MAC_MODE_0    = rw_ff[IX_MAC_MODE_0];
  assign SYSIF_MODE_0  = rw_ff[IX_SYSIF_MODE_0];
  assign SYSIF_MODE_1  = rw_ff[IX_SYSIF_MODE_1];
  assign INT_CONDITION = int_cond_ff;
  assign MASTER_ATTN   = master_attn_ff;

  // checks
  default clocking cb_chk @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  property p_ack_after_start;
    start |=> !CB_ACK_N && (CB_DOE == $past(acc_rd)) && !start;
  endproperty
  a_ack_after_start: assert property (p_ack_after_start)
    else $error("ack missing after access");

  property p_mode0_write;
    acc_wr && (acc_addr == 9'h000) |=> MAC_MODE_0 == $past(acc_data);
  endproperty
  a_mode0_write: assert property (p_mode0_write)
    else $error("mac mode 0 write lost");

  property p_sysif_mode_write;
    acc_wr && (acc_addr == 9'h101) |=> SYSIF_MODE_1 == $past(acc_data) && $stable(SYSIF_MODE_0);
  endproperty
  a_sysif_mode_write: assert property (p_sysif_mode_write)
    else $error("system mode write wrong");

  property p_rx_status_read;
    acc_rd && (acc_addr == 9'h00C) |=> CB_DOUT == $past(rx_status_ff);
  endproperty
  a_rx_status_read: assert property (p_rx_status_read)
    else $error("receiver status read wrong");

  property p_latch_refused;
    acc_wr && (acc_addr == 9'h010) && (lat_ff[L_RING_0] != rw_ff[IX_MAC_COMPARE])
      |=> lat_ff[L_RING_0] == ($past(lat_ff[L_RING_0]) | $past(EV_RING_0));
  endproperty
  a_latch_refused: assert property (p_latch_refused)
    else $error("refused conditional write changed latch");

  property p_attn_accepted;
    acc_wr && (acc_addr == 9'h108) && (lat_ff[L_SERVICE] == sysif_cmp_ff)
      |=> lat_ff[L_SERVICE] == ($past(acc_data) | $past(EV_SERVICE));
  endproperty
  a_attn_accepted: assert property (p_attn_accepted)
    else $error("accepted conditional write lost");

  property p_attn_reset;
    $rose(RST_N) |-> (lat_ff[L_STATE] == 8'h07) && (lat_ff[L_SERVICE] == 8'h0F)
      && (lat_ff[L_NOSPACE] == 8'hFF) && (MASTER_ATTN == 8'h00);
  endproperty
  a_attn_reset: assert property (p_attn_reset)
    else $error("attention reset value wrong");

  property p_int_cond;
    ##1 INT_CONDITION[0] == $past(|(lat_ff[L_RING_0] & rw_ff[IX_RING_MASK_0]));
  endproperty
  a_int_cond: assert property (p_int_cond)
    else $error("interrupt condition wrong");

  property p_reserved;
    acc_rd && (acc_addr == 9'h003) |=> (CB_DOUT == 8'h00) ##1 (CB_DOUT == 8'h00);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved offset read not zero");

  property p_limit_write;
    acc_wr && (acc_addr == 9'h10D)
      |=> limit_ram[$past(limit_addr_ff[LIMIT_AW-1:0])] == $past(acc_data);
  endproperty
  a_limit_write: assert property (p_limit_write)
    else $error("limit data write lost");

endmodule

// ### testbench/cbrm_ctl_model.sv
`timescale 1ns/100ps
module cbrm_ctl_model
  import cbrm_pkg::*;
(
  input  wire logic              clk,
  output logic                   cs_n,
  output logic                   rd,
  output logic      [ADDR_W-1:0] addr,
  output logic      [DATA_W-1:0] din,
  input  wire logic [DATA_W-1:0] dout,
  input  wire logic              ack_n
);
  initial begin
    cs_n = 1'b1;
    rd   = 1'b1;
    addr = 9'h000;
    din  = 8'h00;
  end

  // one access per select period, held until answered or 30 cycles pass
  task automatic access(input logic is_rd, input cbrm_addr_t a, input cbrm_byte_t d,
                        output cbrm_byte_t q, output logic ok);
    int n;
    n = 0;
    @(posedge clk);
    cs_n <= 1'b0;
    rd   <= is_rd;
    addr <= a;
    din  <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack_n !== 1'b0 && n < 30);
    ok = (ack_n === 1'b0);
    q  = dout;
    cs_n <= 1'b1;
    addr <= ~a;
    din  <= ~d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack_n !== 1'b1 && n < 30);
    ok = ok && (ack_n === 1'b1);
    @(posedge clk);
  endtask
endmodule

// ### testbench/tb_control_bus_register_map.sv
`timescale 1ns/100ps
module tb_control_bus_register_map
  import cbrm_pkg::*;
;
  localparam cbrm_addr_t RO_OFS [5] = '{9'h00C, 9'h00E, 9'h02E, 9'h104, 9'h007};
  localparam cbrm_addr_t RES_OFS [5] = '{9'h003, 9'h0C0, 9'h11D, 9'h120, 9'h1FF};
  logic        ref_clk;
  logic        rst_n;
  logic        cs_n;
  logic        rd;
  cbrm_addr_t  addr;
  cbrm_byte_t  din;
  cbrm_byte_t  dout;
  logic        doe;
  logic        ack_n;
  cbrm_byte_t  rx_st;
  cbrm_byte_t  tx_st;
  cbrm_byte_t  ev [NUM_LAT];
  cbrm_byte_t  mode0;
  cbrm_byte_t  smode0;
  cbrm_byte_t  smode1;
  cbrm_byte_t  int_cond;
  cbrm_byte_t  mattn;
  cbrm_byte_t  rw_val [NUM_RW];
  cbrm_byte_t  ro_exp [5];
  cbrm_byte_t  cur;
  cbrm_byte_t  w;
  cbrm_byte_t  e;
  cbrm_addr_t  cmp_ofs;
  logic [31:0] seed;
  int          n_errors;
  int          comparisons;
  int          cycles;

  cbrm_regbank cbrm_regbank_i (
    .REF_CLK        (ref_clk),
    .RST_N          (rst_n),
    .CB_CS_N        (cs_n),
    .CB_READ        (rd),
    .CB_ADDR        (addr),
    .CB_DIN         (din),
    .CB_DOUT        (dout),
    .CB_DOE         (doe),
    .CB_ACK_N       (ack_n),
    .RX_STATUS      (rx_st),
    .TX_STATUS      (tx_st),
    .EV_RING_0      (ev[L_RING_0]),
    .EV_RING_1      (ev[L_RING_1]),
    .EV_TOKEN_TIMER (ev[L_TOKEN]),
    .EV_CNT_INC     (ev[L_CNT_INC]),
    .EV_CNT_OVF     (ev[L_CNT_OVF]),
    .EV_INTERNAL    (ev[L_INTERN]),
    .EV_EXCEPTION   (ev[L_EXC]),
    .EV_STATE       (ev[L_STATE]),
    .EV_SERVICE     (ev[L_SERVICE]),
    .EV_NO_SPACE    (ev[L_NOSPACE]),
    .EV_REQUEST     (ev[L_REQUEST]),
    .MAC_MODE_0     (mode0),
    .SYSIF_MODE_0   (smode0),
    .SYSIF_MODE_1   (smode1),
    .INT_CONDITION  (int_cond),
    .MASTER_ATTN    (mattn)
  );

  cbrm_ctl_model cbrm_ctl_model_i (
    .clk   (ref_clk),
    .cs_n  (cs_n),
    .rd    (rd),
    .addr  (addr),
    .din   (din),
    .dout  (dout),
    .ack_n (ack_n)
  );

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  function automatic cbrm_byte_t rnd8();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  // byte that a conditional write leaves behind
  function automatic cbrm_byte_t cond_exp(cbrm_byte_t c, cbrm_byte_t cmp, cbrm_byte_t d);
    return (c === cmp) ? d : c;
  endfunction

  task automatic check(input cbrm_byte_t got, input cbrm_byte_t exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input cbrm_addr_t a, input cbrm_byte_t d);
    cbrm_byte_t q;
    logic       ok;
    cbrm_ctl_model_i.access(1'b0, a, d, q, ok);
    check({7'h00, ok}, 8'h01);
  endtask

  task automatic rd_chk(input cbrm_addr_t a, input cbrm_byte_t exp);
    cbrm_byte_t q;
    logic       ok;
    cbrm_ctl_model_i.access(1'b1, a, 8'h00, q, ok);
    check({7'h00, ok}, 8'h01);
    check(q, exp);
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
  endtask

  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      results();
    end
  end

  // answer qualifiers while the select stands
  always @(posedge ref_clk) begin
    if (rst_n === 1'b1 && cs_n === 1'b0 && ack_n === 1'b0) begin
      check({7'h00, doe}, {7'h00, rd});
      if (rd === 1'b0) begin
        check(dout, ZERO_BYTE);
      end
    end
  end

  initial begin
    rst_n = 1'b0;
    rx_st = 8'h00;
    tx_st = 8'h00;
    ev = '{default: 8'h00};
    seed = 32'hDF6A;
    n_errors = 0;
    comparisons = 0;
    cycles = 0;
    do_reset();
    foreach (RW_OFS[i]) rd_chk(RW_OFS[i], ZERO_BYTE);
    foreach (LAT_OFS[i]) rd_chk(LAT_OFS[i], LAT_RST[i]);
    rd_chk(OFS_MAILBOX, SYSIF_REVISION);
    check(mode0, ZERO_BYTE);
    check(smode1, ZERO_BYTE);
    $display("test reset_values done");
    @(posedge ref_clk);
    rx_st <= rnd8();
    tx_st <= rnd8();
    @(posedge ref_clk);
    ro_exp = '{rx_st, tx_st, ZERO_BYTE, ZERO_BYTE, MAC_REVISION};
    foreach (RO_OFS[i]) begin
      wr(RO_OFS[i], rnd8());
      rd_chk(RO_OFS[i], ro_exp[i]);
    end
    $display("test read_only done");
    foreach (RW_OFS[i]) rw_val[i] = rnd8();
    rw_val[IX_SYSIF_MODE_0] = ~rw_val[IX_MAC_MODE_0];
    foreach (RW_OFS[i]) wr(RW_OFS[i], rw_val[i]);
    foreach (RW_OFS[i]) rd_chk(RW_OFS[i], rw_val[i]);
    check(mode0, rw_val[IX_MAC_MODE_0]);
    check(smode0, rw_val[IX_SYSIF_MODE_0]);
    check(smode1, rw_val[IX_SYSIF_MODE_1]);
    $display("test read_write done");
    foreach (LAT_OFS[i]) begin
      cmp_ofs = (i < L_STATE) ? RW_OFS[IX_MAC_COMPARE] : OFS_SYSIF_CMP;
      cur = LAT_RST[i];
      w = rnd8();
      if (w == cur) w = ~cur;
      wr(cmp_ofs, ~cur);
      wr(LAT_OFS[i], w);
      rd_chk(LAT_OFS[i], cond_exp(cur, ~cur, w));
      wr(cmp_ofs, cur);
      wr(LAT_OFS[i], w);
      rd_chk(LAT_OFS[i], cond_exp(cur, cur, w));
      e = rnd8();
      @(posedge ref_clk);
      ev[i] <= e;
      @(posedge ref_clk);
      ev[i] <= ZERO_BYTE;
      rd_chk(LAT_OFS[i], w | e);
    end
    $display("test conditional done");
    w = rnd8();
    wr(OFS_SYSIF_CMP, w);
    do_reset();
    rd_chk(OFS_SYSIF_CMP, w);
    rd_chk(LAT_OFS[L_NOSPACE], 8'hFF);
    $display("test second_reset done");
    foreach (RES_OFS[i]) begin
      wr(RES_OFS[i], rnd8());
      rd_chk(RES_OFS[i], ZERO_BYTE);
    end
    rd_chk(RW_OFS[0], ZERO_BYTE);
    rd_chk(RW_OFS[1], ZERO_BYTE);
    $display("test reserved done");
    cur = rnd8();
    e = ~cur;
    wr(OFS_LIMIT_ADDR, 8'h03);
    wr(OFS_LIMIT_DATA, cur);
    wr(OFS_LIMIT_ADDR, 8'h1F);
    wr(OFS_LIMIT_DATA, e);
    wr(OFS_LIMIT_ADDR, 8'h03);
    rd_chk(OFS_LIMIT_DATA, cur);
    wr(OFS_LIMIT_ADDR, 8'h1F);
    rd_chk(OFS_LIMIT_DATA, e);
    wr(OFS_PTR_RAM, cur);
    rd_chk(OFS_PTR_RAM, cur);
    $display("test limit_ram done");
    wr(RW_OFS[IX_STATE_NOTIFY], 8'h01);
    wr(RW_OFS[IX_MASTER_NOTIFY], 8'h01);
    wr(RW_OFS[IX_RING_MASK_0], 8'hFF);
    @(posedge ref_clk);
    ev[L_RING_0] <= 8'h10;
    @(posedge ref_clk);
    ev[L_RING_0] <= ZERO_BYTE;
    rd_chk(OFS_MASTER_ATTN, 8'h01);
    check(mattn, 8'h01);
    rd_chk(OFS_INT_COND, 8'h81);
    check(int_cond, 8'h81);
    $display("test attention done");
    results();
  end
endmodule
